/* arac_regs.vh */
`ifndef ARAC_REGS_VH
`define ARAC_REGS_VH
// register offsets (byte addresses)
`define ARAC_OFF_COMMAND   8'h00
`define ARAC_OFF_STATUS    8'h04
`define ARAC_OFF_CONFIG    8'h08
`define ARAC_OFF_DATA0     8'h10
`define ARAC_OFF_DATA1     8'h14
`define ARAC_OFF_DATA2     8'h18
`define ARAC_OFF_DATA3     8'h1C
// command word fields
`define ARAC_CMDTYPE_HI    31
`define ARAC_CMDTYPE_LO    24
`define ARAC_ZERO_BIT      23
`define ARAC_SIZE_HI       22
`define ARAC_SIZE_LO       20
`define ARAC_POSTINC_BIT   19
`define ARAC_POSTEXEC_BIT  18
`define ARAC_TRANSFER_BIT  17
`define ARAC_WRITE_BIT     16
`define ARAC_REGNO_HI      15
// command kinds
`define ARAC_KIND_ACCREG   8'h00
// access sizes
`define ARAC_SIZE_32       3'h2
`define ARAC_SIZE_64       3'h3
`define ARAC_SIZE_128      3'h4
// register number map
`define ARAC_CSR_LAST      16'h0FFF
`define ARAC_GPR_FIRST     16'h1000
`define ARAC_GPR_LAST      16'h101F
`define ARAC_FPR_FIRST     16'h1020
`define ARAC_FPR_LAST      16'h103F
// error codes
`define ARAC_ERR_NONE      3'h0
`define ARAC_ERR_BUSY      3'h1
`define ARAC_ERR_NOTSUP    3'h2
`define ARAC_ERR_EXCEPT    3'h3
// config register fields
`define ARAC_CFG_HALTED    0
`define ARAC_CFG_PBEXC     1
// axi responses
`define ARAC_RESP_OKAY     2'h0
`define ARAC_RESP_SLVERR   2'h2
`endif

/* arac_core.v */
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// R1: command is 32 bits, top byte kind
// R2: kind 0 selects register access
// R3: read copies register into first slot
// R4: write copies first slot into register
// R5: auto-increment register number after success
// R6: program buffer runs once after transfer
// R7: order transfer, increment, execute; stop on error
// R8: failures may be detected before any step
// R9: missing register gives error code 3
// R10: general-purpose registers always read and writable; here a transfer while the hart is not halted gives 2
// R11: number map csr, gpr, fpr ranges
// R12: size 2,3,4 means 32,64,128 bits
// R13: size above register width fails
// R14: size picks argument width and data words; here a write always takes both data words, cut to register width
// R15: execute bit 0 always allowed
// R16: transfer clear skips register access
// R17: only read changes first slot
// R18: register number is 16 bits
// R19: whole group accessible if one is
// R20: debugger makes registers reachable itself
// R21: core debug registers accessible with csrs; here no csr exists and every csr number gives 3
// R22: unsupported option or nonzero zero-bit gives 2
// R23: debugger loads data before command
// R24: results placed before busy clears
// R25: command word bit layout
`include "arac_regs.vh"
module arac_core #(
   parameter XLEN         = 64,
   parameter PROGBUF_SIZE = 2,
   parameter PB_CYCLES    = 4
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         busy,
   output reg  [2:0]  cmd_error
);
   localparam ST_IDLE = 2'h0;
   localparam ST_XFER = 2'h1;
   localparam ST_EXEC = 2'h2;
   localparam ST_DONE = 2'h3;
   // program buffer model length, cut on purpose to the counter width
   localparam [7:0] PB_LEN = PB_CYCLES;

   // hart register files: gprs and fprs
   reg [XLEN-1:0] gpr [0:31];
   reg [XLEN-1:0] fpr [0:31];
   // debugger data words, first argument slot at the bottom
   reg [31:0]     data_word [0:3];

   // command sequencer state
   reg [1:0]      state;
   reg [31:0]     cmd;            // command word as accepted
   reg [15:0]     regno;          // live register number
   reg [7:0]      pb_count;       // program buffer cycles left

   // configuration: hart run state and fault injection
   reg            hart_halted;
   reg            pb_fault;

   // bus write halves captured until the response is taken
   reg            aw_held;
   reg            w_held;
   reg [31:0]     aw_addr;
   reg [31:0]     w_data;
   reg [3:0]      w_strb;

   // bus write decode: one-cycle strobes once both halves are held
   wire       both_held = aw_held && w_held && !s_axi_bvalid;
   wire [7:0] wofs      = aw_addr[7:0];
   // full-word write of the command word starts a command
   wire       cmd_go    = both_held && wofs == `ARAC_OFF_COMMAND &&
                          (&w_strb);
   // configuration and data word writes
   wire       cfg_go    = both_held && wofs == `ARAC_OFF_CONFIG;
   wire       data_go   = both_held && wofs[7:4] == 4'h1;
   // addresses that answer okay; the rest get a slave error
   wire       wr_ok     = wofs == `ARAC_OFF_COMMAND ||
                          wofs == `ARAC_OFF_CONFIG ||
                          wofs[7:4] == 4'h1;

   // command field decode
   wire [7:0] cmd_kind = cmd[`ARAC_CMDTYPE_HI:`ARAC_CMDTYPE_LO]; // see R1
   wire [2:0] cmd_size = cmd[`ARAC_SIZE_HI:`ARAC_SIZE_LO]; // see R25
   wire cmd_inc  = cmd[`ARAC_POSTINC_BIT];
   wire cmd_exec = cmd[`ARAC_POSTEXEC_BIT];
   wire cmd_xfer = cmd[`ARAC_TRANSFER_BIT];
   wire cmd_wr   = cmd[`ARAC_WRITE_BIT];
   wire [15:0] cmd_reg = cmd[`ARAC_REGNO_HI:0]; // see R18

   // register group of the number, see map
   wire is_gpr = (cmd_reg >= `ARAC_GPR_FIRST) &&
                 (cmd_reg <= `ARAC_GPR_LAST); // see R11
   wire is_fpr = (cmd_reg >= `ARAC_FPR_FIRST) &&
                 (cmd_reg <= `ARAC_FPR_LAST); // see R11
   wire [4:0] ridx = cmd_reg[4:0];
   // size legality against register width
   wire size_ok = (cmd_size == `ARAC_SIZE_32) ||
                  ((cmd_size == `ARAC_SIZE_64) && (XLEN >= 64)); // see R13

   // refusal reasons, checked before any step runs
   wire bad_form  = (cmd_kind != `ARAC_KIND_ACCREG) ||
                    cmd[`ARAC_ZERO_BIT]; // see R2 see R22
   wire bad_exec  = cmd_exec && (PROGBUF_SIZE == 0); // see R15
   wire bad_state = cmd_xfer && !hart_halted; // see R10
   wire bad_size  = cmd_xfer && !size_ok; // see R12 see R13
   wire bad_reg   = cmd_xfer && !is_gpr && !is_fpr; // see R9
   // csrs and numbers above the fprs do not exist here, so they
   // raise the exception code rather than not supported

   // up-front failure check, first reason wins
   reg [2:0] pre_err;
   always @* begin
      pre_err = `ARAC_ERR_NONE;
      if (bad_form)
         pre_err = `ARAC_ERR_NOTSUP;
      else if (bad_exec)
         pre_err = `ARAC_ERR_NOTSUP;
      else if (bad_state)
         pre_err = `ARAC_ERR_NOTSUP;
      else if (bad_size)
         pre_err = `ARAC_ERR_NOTSUP;
      else if (bad_reg)
         pre_err = `ARAC_ERR_EXCEPT; // see R8 see R19 see R21
   end

   // selected register value, zero-extended to two data words
   wire [XLEN-1:0] reg_val = is_gpr ? gpr[ridx] : fpr[ridx];
   reg  [63:0]     reg_wide;
   always @* begin
      reg_wide           = 64'h0;
      reg_wide[XLEN-1:0] = reg_val; // a 32-bit hart leaves high word 0
   end
   // argument as the debugger loaded it, low word first
   wire [63:0]     arg_val = {data_word[1], data_word[0]};

   // transfer step strobes; only taken when no refusal is pending
   wire step_ok = (state == ST_XFER) && (pre_err == `ARAC_ERR_NONE);
   wire rd_go   = step_ok && cmd_xfer && !cmd_wr; // see R3
   wire gpr_we  = step_ok && cmd_xfer && cmd_wr && is_gpr; // see R4
   wire fpr_we  = step_ok && cmd_xfer && cmd_wr && is_fpr; // see R4

   // hart register files, one write port per entry; x0 stays zero
   genvar k;
   generate
      for (k = 0; k < 32; k = k + 1) begin : g_regfile
         localparam [4:0] IDX = k;
         always @(posedge aclk) begin
            if (!aresetn) begin
               gpr[k] <= {XLEN{1'b0}};
               fpr[k] <= {XLEN{1'b0}};
            end else begin
               if (gpr_we && ridx == IDX && IDX != 5'h0)
                  gpr[k] <= arg_val[XLEN-1:0]; // see R4
               if (fpr_we && ridx == IDX)
                  fpr[k] <= arg_val[XLEN-1:0]; // see R4
            end
         end
      end
   endgenerate

   // command sequencer
   always @(posedge aclk) begin
      if (!aresetn) begin
         state     <= ST_IDLE;
         busy      <= 1'b0;
         cmd_error <= `ARAC_ERR_NONE;
         cmd       <= 32'h0;
         regno     <= 16'h0;
         pb_count  <= 8'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cmd_go) begin
                  cmd   <= w_data;
                  regno <= w_data[`ARAC_REGNO_HI:0];
                  busy  <= 1'b1;
                  state <= ST_XFER;
               end
            end
            ST_XFER: begin
               if (pre_err != `ARAC_ERR_NONE) begin
                  cmd_error <= pre_err; // see R8
                  busy      <= 1'b0;
                  state     <= ST_IDLE; // see R7
               end else begin
                  // register files take the write in this same cycle
                  if (cmd_inc && cmd_xfer)
                     regno <= regno + 16'h1; // see R5
                  pb_count <= PB_LEN;
                  state <= cmd_exec ? ST_EXEC : ST_DONE; // see R6 see R16
               end
            end
            ST_EXEC: begin
               // program buffer runs once; fault ends it
               if (pb_fault) begin
                  cmd_error <= `ARAC_ERR_EXCEPT;
                  state     <= ST_DONE;
               end else if (pb_count <= 8'h1)
                  state <= ST_DONE;
               else
                  pb_count <= pb_count - 8'h1;
            end
            // results already sit in the data words here
            ST_DONE: begin
               busy  <= 1'b0; // see R24
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
         // command while busy flags busy error
         if (cmd_go && state != ST_IDLE)
            cmd_error <= `ARAC_ERR_BUSY;
         // write-one-to-clear of error code
         if (cfg_go && w_data[10:8] != 3'h0 && !busy)
            cmd_error <= `ARAC_ERR_NONE;
      end
   end

   // data words, one per entry: read results or bus writes
   genvar n;
   generate
      for (n = 0; n < 4; n = n + 1) begin : g_data
         localparam [1:0] SLOT = n;
         // read result lands in the argument slot words only
         wire res_we = rd_go && ((SLOT == 2'h0) ||
                       (SLOT == 2'h1 && cmd_size == `ARAC_SIZE_64)); // see R17
         // debugger loads are ignored while a command runs
         wire bus_we = data_go && !busy && aw_addr[3:2] == SLOT;
         always @(posedge aclk) begin
            if (!aresetn)
               data_word[n] <= 32'h0;
            else if (res_we)
               data_word[n] <= reg_wide[32*(n%2) +: 32]; // see R3 see R14
            else if (bus_we)
               data_word[n] <= w_data; // see R23
         end
      end
   endgenerate

   // next ready values: one-cycle pulses, none while a half is held
   // or a read answer is still waiting
   reg next_awready;
   reg next_wready;
   reg next_arready;
   always @* begin
      next_awready = !aw_held && !s_axi_awready && s_axi_awvalid;
      next_wready  = !w_held && !s_axi_wready && s_axi_wvalid;
      next_arready = !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
   end

   // bus write path: address and data in any order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `ARAC_RESP_OKAY;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 32'h0;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
         hart_halted   <= 1'b1;
         pb_fault      <= 1'b0;
      end else begin
         // a held half is not taken again until the response is gone
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         // answer once, when both halves are in
         if (both_held) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `ARAC_RESP_OKAY : `ARAC_RESP_SLVERR;
            if (cfg_go) begin
               hart_halted <= w_data[`ARAC_CFG_HALTED];
               pb_fault    <= w_data[`ARAC_CFG_PBEXC];
            end
         end
         // response taken: free both halves for the next write
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
         end
      end
   end

   // bus read path
   reg [31:0] rd_word;
   reg        rd_ok;
   always @* begin
      rd_ok   = 1'b1;
      rd_word = 32'h0;
      case (s_axi_araddr[7:0])
         // low half shows the live, possibly incremented, number
         `ARAC_OFF_COMMAND: rd_word = {cmd[31:16], regno}; // see R5
         `ARAC_OFF_STATUS:  rd_word = {19'h0, busy, 1'b0, cmd_error, 8'h0};
         `ARAC_OFF_CONFIG:  rd_word = {30'h0, pb_fault, hart_halted};
         `ARAC_OFF_DATA0:   rd_word = data_word[0];
         `ARAC_OFF_DATA1:   rd_word = data_word[1];
         `ARAC_OFF_DATA2:   rd_word = data_word[2];
         `ARAC_OFF_DATA3:   rd_word = data_word[3];
         default:           rd_ok   = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `ARAC_RESP_OKAY;
      end else begin
         // read data is captured at the address handshake
         s_axi_arready <= next_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? `ARAC_RESP_OKAY : `ARAC_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule // arac_core

/* arac_dbg.sv */
`timescale 1ns/1ps
// axi4-lite master standing in for the debugger
module arac_dbg (
   input  wire         aclk,
   output logic [31:0] awaddr,
   output logic        awvalid,
   input  wire         awready,
   output logic [31:0] wdata,
   output logic [3:0]  wstrb,
   output logic        wvalid,
   input  wire         wready,
   input  wire  [1:0]  bresp,
   input  wire         bvalid,
   output logic        bready,
   output logic [31:0] araddr,
   output logic        arvalid,
   input  wire         arready,
   input  wire  [31:0] rdata,
   input  wire  [1:0]  rresp,
   input  wire         rvalid,
   output logic        rready
);
   // idle bus from time zero
   initial begin
      {awaddr, wdata, araddr} = 96'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      wstrb = 4'hF;
   end
   // write: address and data offered together, released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic aw_t, w_t, b_t;
      @(posedge aclk);
      awaddr <= {24'h000000, a};
      wdata  <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         // sample what the slave will see at the coming edge
         @(negedge aclk);
         {aw_t, w_t, b_t} = {awready & awvalid, wready & wvalid, bvalid};
         r = bresp;
         @(posedge aclk);
         if (aw_t) {awvalid, awaddr} <= {1'b0, ~awaddr};
         if (w_t) {wvalid, wdata} <= {1'b0, ~wdata};
      end while (!b_t);
      bready <= 1'b0;
   endtask
   // read: address held until taken, data taken with rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      logic ar_t, r_t;
      @(posedge aclk);
      araddr <= {24'h000000, a};
      {arvalid, rready} <= 2'h3;
      do begin
         @(negedge aclk);
         {ar_t, r_t} = {arready & arvalid, rvalid};
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ar_t) {arvalid, araddr} <= {1'b0, ~araddr};
      end while (!r_t);
      rready <= 1'b0;
   endtask
endmodule // arac_dbg

/* arac_chk.sv */
`timescale 1ns/1ps
module arac_chk (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        busy,
   input wire [2:0]  cmd_error
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // command start as seen at the ports
   sequence s_start;
      $rose(busy);
   endsequence
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
   AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready not a pulse");
   AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("rvalid late");
   AST_BUSY_MIN: assert property (s_start |=> busy || cmd_error != 3'h0)
      else $error("busy too short");
   AST_BUSY_END: assert property (busy |-> ##[0:12] !busy)
      else $error("busy hung");
   AST_ERR_CAUSE: assert property ($changed(cmd_error) &&
      cmd_error != 3'h0 |-> $past(busy)) else $error("stray error code");
   AST_RESET_IDLE: assert property ($rose(aresetn) |->
      !busy && cmd_error == 3'h0) else $error("not idle after reset");
endmodule // arac_chk
bind arac_core arac_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .busy(busy), .cmd_error(cmd_error));

/* abstract_register_access_tb.sv */
`timescale 1ns/1ps
`include "arac_regs.vh"
module abstract_register_access_tb;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   wire  [31:0] awaddr, wdata, araddr, rdata;
   wire  [3:0]  wstrb;
   wire  [1:0]  bresp, rresp;
   wire  [2:0]  cmd_error;
   wire         awvalid, awready, wvalid, wready, bvalid, bready;
   wire         arvalid, arready, rvalid, rready, busy;
   int          error_cnt = 0;
   int          n_tests = 0;
   logic [31:0] rv, cfg;
   logic [1:0]  rs;
   always #20 aclk = ~aclk;
   arac_core #(.XLEN(64), .PROGBUF_SIZE(2), .PB_CYCLES(4)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .busy(busy), .cmd_error(cmd_error));
   arac_dbg u_dbg (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   task chk(input string nm, input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task close_out;
      if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // command word: kind, size, increment, execute, transfer, write, number
   function logic [31:0] ac(input logic [7:0] k, input logic [2:0] sz,
      input logic pi, pe, tr, wr, input logic [15:0] rg);
      return {k, 1'b0, sz, pi, pe, tr, wr, rg};
   endfunction
   // issue a command, poll until idle, check and clear the error code
   task cmd(input logic [31:0] c, input logic [2:0] e);
      u_dbg.wr(`ARAC_OFF_COMMAND, c, rs);
      rv = 32'h0000_1000;
      for (int i = 0; i < 40 && rv[12]; i++) u_dbg.rd(`ARAC_OFF_STATUS, rv, rs);
      chk("status", {28'h0, rv[12], rv[10:8]}, {29'h0, e});
      chk("cmd_error", {29'h0, cmd_error}, {29'h0, e});
      if (e != 3'h0) u_dbg.wr(`ARAC_OFF_CONFIG, cfg | 32'h0000_0700, rs);
   endtask
   task t_reset;
      u_dbg.rd(`ARAC_OFF_STATUS, rv, rs);
      chk("status rst", rv, 32'h0);
      u_dbg.rd(8'h40, rv, rs);
      chk("unmapped", {30'h0, rs}, {30'h0, `ARAC_RESP_SLVERR});
      u_dbg.wr(8'h40, 32'h0, rs);
      chk("wr unmapped", {30'h0, rs}, {30'h0, `ARAC_RESP_SLVERR});
   endtask
   task t_gpr;
      u_dbg.wr(`ARAC_OFF_DATA0, 32'h1234_5678, rs);
      u_dbg.wr(`ARAC_OFF_DATA1, 32'h9ABC_DEF0, rs);
      u_dbg.wr(`ARAC_OFF_DATA2, 32'h5555_AAAA, rs);
      cmd(ac(8'h00, `ARAC_SIZE_64, 0, 0, 1, 1, 16'h1005), 3'h0);
      u_dbg.wr(`ARAC_OFF_DATA0, 32'h0, rs);
      u_dbg.wr(`ARAC_OFF_DATA1, 32'h0, rs);
      cmd(ac(8'h00, `ARAC_SIZE_64, 0, 0, 1, 0, 16'h1005), 3'h0);
      u_dbg.rd(`ARAC_OFF_DATA0, rv, rs);
      chk("data0", rv, 32'h1234_5678);
      u_dbg.rd(`ARAC_OFF_DATA1, rv, rs);
      chk("data1", rv, 32'h9ABC_DEF0);
      u_dbg.rd(`ARAC_OFF_DATA2, rv, rs);
      chk("data2", rv, 32'h5555_AAAA);
   endtask
   task t_size32;
      u_dbg.wr(`ARAC_OFF_DATA1, 32'h0F0F_0F0F, rs);
      cmd(ac(8'h00, `ARAC_SIZE_32, 1, 0, 1, 0, 16'h1005), 3'h0);
      u_dbg.rd(`ARAC_OFF_DATA1, rv, rs);
      chk("data1 kept", rv, 32'h0F0F_0F0F);
      u_dbg.rd(`ARAC_OFF_COMMAND, rv, rs);
      chk("regno inc", {16'h0, rv[15:0]}, 32'h0000_1006);
   endtask
   task t_errors;
      cmd(ac(8'h01, `ARAC_SIZE_64, 0, 0, 1, 0, 16'h1005), 3'h2);
      cmd(ac(8'h00, `ARAC_SIZE_64, 0, 0, 1, 0, 16'h1005) | 32'h0080_0000,
          3'h2);
      cmd(ac(8'h00, `ARAC_SIZE_128, 0, 0, 1, 0, 16'h1005), 3'h2);
      cmd(ac(8'h00, `ARAC_SIZE_64, 0, 0, 1, 0, 16'h1040), 3'h3);
      cmd(ac(8'h00, `ARAC_SIZE_64, 1, 0, 1, 0, 16'h0300), 3'h3);
      u_dbg.rd(`ARAC_OFF_COMMAND, rv, rs);
      chk("regno kept", {16'h0, rv[15:0]}, 32'h0000_0300);
      cfg = 32'h0000_0000;
      u_dbg.wr(`ARAC_OFF_CONFIG, cfg, rs);
      cmd(ac(8'h00, `ARAC_SIZE_64, 0, 0, 1, 0, 16'h1005), 3'h2);
      cfg = 32'h0000_0001;
      u_dbg.wr(`ARAC_OFF_CONFIG, cfg, rs);
   endtask
   task t_exec;
      cfg = 32'h0000_0003;
      u_dbg.wr(`ARAC_OFF_CONFIG, cfg, rs);
      u_dbg.wr(`ARAC_OFF_DATA0, 32'h0, rs);
      cmd(ac(8'h00, `ARAC_SIZE_64, 0, 1, 1, 0, 16'h1005), 3'h3);
      u_dbg.rd(`ARAC_OFF_DATA0, rv, rs);
      chk("xfer first", rv, 32'h1234_5678);
      cfg = 32'h0000_0001;
      u_dbg.wr(`ARAC_OFF_CONFIG, cfg, rs);
      cmd(ac(8'h00, 3'h7, 0, 1, 0, 0, 16'hFFFF), 3'h0);
      u_dbg.wr(`ARAC_OFF_COMMAND, ac(8'h00, 3'h0, 0, 1, 0, 0, 16'h0), rs);
      cmd(ac(8'h00, `ARAC_SIZE_64, 0, 0, 1, 0, 16'h1005), 3'h1);
   endtask
   // watchdog well beyond the expected run
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      close_out;
   end
   initial begin
      cfg = 32'h0000_0001;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_gpr;
      t_size32;
      t_errors;
      t_exec;
      close_out;
   end
endmodule // abstract_register_access_tb
